// *** rtl/cfg_pkg.sv ***
package cfg_pkg;

  // Register widths
  localparam int PERSIST_W = 16;
  localparam int RUNTIME_W = 8;
  localparam int OPCODE_W = 8;

  // Command codes on the serial link, defaults of our own
  localparam logic [7:0] OP_RD_PERSIST = 8'hb5;
  localparam logic [7:0] OP_WR_PERSIST = 8'hb1;
  localparam logic [7:0] OP_RD_RUNTIME = 8'h85;
  localparam logic [7:0] OP_WR_RUNTIME = 8'h81;

  // Persistent word field positions
  localparam int P_DUMMY_HI = 15;
  localparam int P_DUMMY_LO = 12;
  localparam int P_EXEC_HI = 11;
  localparam int P_EXEC_LO = 9;
  localparam int P_DRV_HI = 8;
  localparam int P_DRV_LO = 6;
  localparam int P_DTR = 5;
  localparam int P_HOLD = 4;
  localparam int P_QUAD = 3;
  localparam int P_DUAL = 2;
  localparam int P_SEG = 1;
  localparam int P_ADDR = 0;

  // Runtime word field positions
  localparam int R_DUMMY_HI = 7;
  localparam int R_DUMMY_LO = 4;
  localparam int R_EXEC = 3;
  localparam int R_RSVD = 2;
  localparam int R_WRAP_HI = 1;
  localparam int R_WRAP_LO = 0;

  // Reset and code values
  localparam logic [15:0] PERSIST_FACTORY = 16'hffff;
  localparam logic [7:0] RUNTIME_RESET = 8'hfb;
  localparam logic [3:0] DUMMY_ZERO = 4'h0;
  localparam logic [3:0] DUMMY_DEFAULT_CODE = 4'hf;
  localparam logic [3:0] DUMMY_DEFAULT_CYCLES = 4'ha;
  localparam logic [2:0] EXEC_OFF_CODE = 3'h7;
  localparam logic [2:0] DRV_DEFAULT = 3'h7;
  localparam logic [1:0] WRAP_16 = 2'h0;
  localparam logic [1:0] WRAP_32 = 2'h1;
  localparam logic [1:0] WRAP_64 = 2'h2;
  localparam logic [1:0] WRAP_CONT = 2'h3;
  localparam logic [5:0] MASK_16 = 6'h0f;
  localparam logic [5:0] MASK_32 = 6'h1f;
  localparam logic [5:0] MASK_64 = 6'h3f;
  localparam logic [5:0] MASK_NONE = 6'h00;

  // Link bit counter
  localparam int CNT_W = 6;
  localparam logic [5:0] CNT_MAX = 6'h3f;
  localparam logic [5:0] CNT_OPCODE = 6'h08;
  localparam logic [5:0] CNT_PERSIST_LAST = 6'h17;
  localparam logic [5:0] CNT_RUNTIME_LAST = 6'h0f;
  localparam logic [4:0] RD_LEN_PERSIST = 5'h10;
  localparam logic [4:0] RD_LEN_RUNTIME = 5'h08;

  // Persistent cell program time
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_NS = 1000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CNT_W = 12;

endpackage

// *** rtl/persist_cell.sv ***
`timescale 1ns/10ps
// Persistent 16-bit word: survives device reset, only power-on restores factory value
module persist_cell #(
  parameter int PROG_CYCLES = cfg_pkg::PROG_CYCLES
) (
  input wire logic mclk_in,
  input wire logic por_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [15:0] wdata_in,
  output logic busy_out,
  output logic [15:0] rdata_out
);

  logic [cfg_pkg::PROG_CNT_W-1:0] cnt_reg;
  logic [cfg_pkg::PROG_CNT_W-1:0] cnt_next;
  logic [15:0] pend_reg;
  logic busy_next;
  logic done;

  // Program timer; a start during busy is ignored
  assign done = busy_out && (cnt_reg == cfg_pkg::PROG_CNT_W'(PROG_CYCLES - 1));
  assign busy_next = (start_in && !busy_out) || (busy_out && !done);
  assign cnt_next = busy_out ? cnt_reg + 1'b1 : '0;

  // Control side follows device reset
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      cnt_reg <= '0;
      pend_reg <= '0;
    end else begin
      busy_out <= busy_next;
      cnt_reg <= cnt_next;
      if (start_in && !busy_out) begin
        pend_reg <= wdata_in;
      end
    end
  end

  // Stored word only changes once the program time has run out
  always_ff @(posedge mclk_in or posedge por_in) begin
    if (por_in) begin
      rdata_out <= cfg_pkg::PERSIST_FACTORY;
    end else if (done && !rst_in) begin
      rdata_out <= pend_reg;
    end
  end

endmodule

// *** rtl/flash_config_registers.sv ***
`timescale 1ns/10ps
// Contract
// - At power-on and every reset, persistent word loads the internal configuration.
// - Persistent word is read and written only by its own link commands.
// - Persistent bits 15:12 set dummy cycles; 0000 acts as 1111, the default.
// - Persistent bits 11:9 pick the execute-in-place mode entered after reset.
// - Persistent bits 8:6 pick driver strength; 111 default, even codes reserved.
// - Persistent bit 5 cleared makes every command double transfer rate.
// - Persistent bit 4 set lets data line three act as hold or reset.
// - Persistent bit 3 cleared enables the quad command protocol.
// - Persistent bit 2 cleared enables the dual command protocol.
// - Both bits 2 and 3 cleared gives quad, which beats dual.
// - Persistent bit 1 picks power-on segment: 0 highest, 1 lowest.
// - Persistent bit 0 picks address length: 0 four bytes, 1 three.
// - Runtime word write takes effect when the command ends; read returns it.
// - Runtime bits 7:4 set dummy cycles with the persistent encoding.
// - Runtime bit 3 cleared enables execute-in-place; bit 2 reads zero.
// - Runtime wrap codes 00, 01, 10 wrap reads in 16, 32, 64 bytes.
// - Runtime wrap code 11 reads continuously through the whole array.
// - Controller ready flag shows busy while the persistent word programs.
module flash_config_registers #(
  parameter logic [3:0] DUMMY_DEFAULT = cfg_pkg::DUMMY_DEFAULT_CYCLES,
  parameter int PROG_CYCLES = cfg_pkg::PROG_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic por_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic dq0_in,
  output logic dq1_out,
  output logic dq1_oe_out,
  output logic [3:0] dummy_cycles_out,
  output logic [2:0] exec_mode_out,
  output logic execute_in_place_mode_out,
  output logic [2:0] driver_strength_out,
  output logic dtr_enable_out,
  output logic data_line_three_hold_out,
  output logic quad_protocol_out,
  output logic dual_protocol_out,
  output logic segment_high_out,
  output logic four_byte_addr_out,
  output logic wrap_continuous_out,
  output logic [5:0] wrap_mask_out,
  output logic pe_ready_out
);

  // Resets: power-on implies device reset; deselect clears the link frame
  logic core_rst;
  logic link_rst;
  assign core_rst = rst_in | por_in;
  assign link_rst = cs_n_in | core_rst;

  // ---------------- Link domain, serial clock ----------------
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [7:0] op_reg;
  logic [15:0] sh_reg;
  logic [15:0] word_in;
  logic [15:0] hold_word_reg;
  logic hold_persist_reg;
  logic req_tgl_reg;
  logic op_rd_persist;
  logic op_wr_persist;
  logic op_rd_runtime;
  logic op_wr_runtime;
  logic wr_persist_last;
  logic wr_runtime_last;
  logic commit;
  logic [15:0] rd_sh_reg;
  logic [4:0] rd_left_reg;
  logic [15:0] rd_src;
  logic [4:0] rd_len;
  logic rd_load;

  // Only the dedicated command codes reach the words
  assign op_rd_persist = (op_reg == cfg_pkg::OP_RD_PERSIST);
  assign op_wr_persist = (op_reg == cfg_pkg::OP_WR_PERSIST);
  assign op_rd_runtime = (op_reg == cfg_pkg::OP_RD_RUNTIME);
  assign op_wr_runtime = (op_reg == cfg_pkg::OP_WR_RUNTIME);

  // Commit on the edge that takes the last data bit; extra bits are ignored
  assign wr_persist_last = op_wr_persist && (cnt_reg == cfg_pkg::CNT_PERSIST_LAST);
  assign wr_runtime_last = op_wr_runtime && (cnt_reg == cfg_pkg::CNT_RUNTIME_LAST);
  assign commit = wr_persist_last || wr_runtime_last;
  assign word_in = {sh_reg[14:0], dq0_in};
  assign cnt_next = (cnt_reg == cfg_pkg::CNT_MAX) ? cnt_reg : cnt_reg + 1'b1;

  // Frame shifter: opcode first, then data, both MSB first
  always_ff @(posedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      cnt_reg <= '0;
      op_reg <= '0;
      sh_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      if (cnt_reg < cfg_pkg::CNT_OPCODE) begin
        op_reg <= {op_reg[6:0], dq0_in};
      end else begin
        sh_reg <= word_in;
      end
    end
  end

  // Held word and toggle outlive the frame, since the clock stops at deselect
  always_ff @(posedge sclk_in or posedge core_rst) begin
    if (core_rst) begin
      hold_word_reg <= '0;
      hold_persist_reg <= 1'b0;
      req_tgl_reg <= 1'b0;
    end else if (commit) begin
      hold_word_reg <= word_in;
      hold_persist_reg <= wr_persist_last;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // Read source; words change only after a commit, so they are quasi-static here
  logic [15:0] persist_word;
  logic [7:0] runtime_reg;
  assign rd_src = op_rd_persist ? persist_word : {runtime_reg, 8'h00};
  assign rd_len = op_rd_persist ? cfg_pkg::RD_LEN_PERSIST : cfg_pkg::RD_LEN_RUNTIME;
  assign rd_load = (op_rd_persist || op_rd_runtime) &&
                   ((cnt_reg == cfg_pkg::CNT_OPCODE) || (rd_left_reg == 5'h00 && dq1_oe_out));

  // Read data launched on the falling edge, word repeats while selected
  always_ff @(negedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      rd_sh_reg <= '0;
      rd_left_reg <= '0;
      dq1_out <= 1'b0;
      dq1_oe_out <= 1'b0;
    end else if (rd_load && cnt_reg >= cfg_pkg::CNT_OPCODE) begin
      dq1_out <= rd_src[15];
      rd_sh_reg <= {rd_src[14:0], 1'b0};
      rd_left_reg <= rd_len - 5'h01;
      dq1_oe_out <= 1'b1;
    end else if (dq1_oe_out) begin
      dq1_out <= rd_sh_reg[15];
      rd_sh_reg <= {rd_sh_reg[14:0], 1'b0};
      rd_left_reg <= rd_left_reg - 5'h01;
    end
  end

  // ---------------- Core domain, system clock ----------------
  logic tgl_sync1_reg;
  logic tgl_sync2_reg;
  logic tgl_seen_reg;
  logic wr_event;
  logic wr_persist;
  logic wr_runtime;
  logic load_pending_reg;
  logic prog_busy;

  // Toggle crossing; first stage read only by second
  always_ff @(posedge mclk_in or posedge core_rst) begin
    if (core_rst) begin
      tgl_sync1_reg <= 1'b0;
      tgl_sync2_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
    end else begin
      tgl_sync1_reg <= req_tgl_reg;
      tgl_sync2_reg <= tgl_sync1_reg;
      tgl_seen_reg <= tgl_sync2_reg;
    end
  end

  // Held word is stable long before the toggle is seen here
  assign wr_event = tgl_sync2_reg ^ tgl_seen_reg;
  assign wr_persist = wr_event && hold_persist_reg;
  assign wr_runtime = wr_event && !hold_persist_reg;

  persist_cell #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_persist (
    .mclk_in(mclk_in),
    .por_in(por_in),
    .rst_in(core_rst),
    .start_in(wr_persist),
    .wdata_in(hold_word_reg),
    .busy_out(prog_busy),
    .rdata_out(persist_word)
  );

  // Decode of the persistent word
  logic [3:0] p_dummy_code;
  logic [3:0] p_dummy;
  logic [2:0] p_exec;
  logic [2:0] p_drv;
  logic [2:0] p_drv_dec;
  logic p_quad;
  logic p_dual;
  assign p_dummy_code = persist_word[cfg_pkg::P_DUMMY_HI:cfg_pkg::P_DUMMY_LO];
  assign p_dummy = (p_dummy_code == cfg_pkg::DUMMY_ZERO ||
                    p_dummy_code == cfg_pkg::DUMMY_DEFAULT_CODE) ?
                   DUMMY_DEFAULT : p_dummy_code;
  assign p_exec = persist_word[cfg_pkg::P_EXEC_HI:cfg_pkg::P_EXEC_LO];
  assign p_drv = persist_word[cfg_pkg::P_DRV_HI:cfg_pkg::P_DRV_LO];
  // Valid strengths are the odd codes; reserved ones fall back to default
  assign p_drv_dec = p_drv[0] ? p_drv : cfg_pkg::DRV_DEFAULT;
  assign p_quad = ~persist_word[cfg_pkg::P_QUAD];
  assign p_dual = ~persist_word[cfg_pkg::P_DUAL] & ~p_quad;

  // Decode of an incoming runtime word
  logic [7:0] r_word;
  logic [3:0] r_dummy_code;
  logic [3:0] r_dummy;
  logic [1:0] r_wrap;
  logic [5:0] r_mask;
  assign r_word = {hold_word_reg[7:3], 1'b0, hold_word_reg[1:0]};
  assign r_dummy_code = r_word[cfg_pkg::R_DUMMY_HI:cfg_pkg::R_DUMMY_LO];
  assign r_dummy = (r_dummy_code == cfg_pkg::DUMMY_ZERO ||
                    r_dummy_code == cfg_pkg::DUMMY_DEFAULT_CODE) ?
                   DUMMY_DEFAULT : r_dummy_code;
  assign r_wrap = r_word[cfg_pkg::R_WRAP_HI:cfg_pkg::R_WRAP_LO];
  assign r_mask = (r_wrap == cfg_pkg::WRAP_16) ? cfg_pkg::MASK_16 :
                  (r_wrap == cfg_pkg::WRAP_32) ? cfg_pkg::MASK_32 :
                  (r_wrap == cfg_pkg::WRAP_64) ? cfg_pkg::MASK_64 :
                  cfg_pkg::MASK_NONE;

  // Runtime word seeded from the persistent one at each load
  logic [7:0] r_seed;
  assign r_seed = {persist_word[cfg_pkg::P_DUMMY_HI:cfg_pkg::P_DUMMY_LO],
                   (p_exec == cfg_pkg::EXEC_OFF_CODE), 1'b0,
                   cfg_pkg::RUNTIME_RESET[cfg_pkg::R_WRAP_HI:cfg_pkg::R_WRAP_LO]};

  // Load request caught after reset release, never inside the reset branch
  always_ff @(posedge mclk_in or posedge core_rst) begin
    if (core_rst) begin
      load_pending_reg <= 1'b1;
    end else begin
      load_pending_reg <= 1'b0;
    end
  end

  // Runtime register: reset value, then seed, then host writes
  always_ff @(posedge mclk_in or posedge core_rst) begin
    if (core_rst) begin
      runtime_reg <= cfg_pkg::RUNTIME_RESET;
    end else if (load_pending_reg) begin
      runtime_reg <= r_seed;
    end else if (wr_runtime) begin
      runtime_reg <= r_word;
    end
  end

  // Fields owned only by the persistent word; later persistent writes wait
  // for the next reset so an in-flight setting never changes mid-operation
  always_ff @(posedge mclk_in or posedge core_rst) begin
    if (core_rst) begin
      exec_mode_out <= cfg_pkg::EXEC_OFF_CODE;
      driver_strength_out <= cfg_pkg::DRV_DEFAULT;
      dtr_enable_out <= 1'b0;
      data_line_three_hold_out <= 1'b1;
      quad_protocol_out <= 1'b0;
      dual_protocol_out <= 1'b0;
      segment_high_out <= 1'b0;
      four_byte_addr_out <= 1'b0;
    end else if (load_pending_reg) begin
      exec_mode_out <= p_exec;
      driver_strength_out <= p_drv_dec;
      dtr_enable_out <= ~persist_word[cfg_pkg::P_DTR];
      data_line_three_hold_out <= persist_word[cfg_pkg::P_HOLD];
      quad_protocol_out <= p_quad;
      dual_protocol_out <= p_dual;
      segment_high_out <= ~persist_word[cfg_pkg::P_SEG];
      four_byte_addr_out <= ~persist_word[cfg_pkg::P_ADDR];
    end
  end

  // Fields shared with the runtime word: last of load or runtime write wins
  always_ff @(posedge mclk_in or posedge core_rst) begin
    if (core_rst) begin
      dummy_cycles_out <= DUMMY_DEFAULT;
      execute_in_place_mode_out <= 1'b0;
      wrap_continuous_out <= 1'b1;
      wrap_mask_out <= cfg_pkg::MASK_NONE;
    end else if (load_pending_reg) begin
      dummy_cycles_out <= p_dummy;
      execute_in_place_mode_out <= (p_exec != cfg_pkg::EXEC_OFF_CODE);
      wrap_continuous_out <= 1'b1;
      wrap_mask_out <= cfg_pkg::MASK_NONE;
    end else if (wr_runtime) begin
      dummy_cycles_out <= r_dummy;
      execute_in_place_mode_out <= ~r_word[cfg_pkg::R_EXEC];
      wrap_continuous_out <= (r_wrap == cfg_pkg::WRAP_CONT);
      wrap_mask_out <= r_mask;
    end
  end

  // Ready flag low from the write event until programming ends
  always_ff @(posedge mclk_in or posedge core_rst) begin
    if (core_rst) begin
      pe_ready_out <= 1'b1;
    end else begin
      pe_ready_out <= ~(prog_busy || wr_persist);
    end
  end

endmodule

// *** verif/flash_config_checker.sv ***
`timescale 1ns/10ps
module flash_config_checker #(
  parameter int PROG_CYCLES = cfg_pkg::PROG_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic por_in,
  input wire logic cs_n_in,
  input wire logic dq1_oe_out,
  input wire logic [3:0] dummy_cycles_out,
  input wire logic [2:0] exec_mode_out,
  input wire logic [2:0] driver_strength_out,
  input wire logic dtr_enable_out,
  input wire logic data_line_three_hold_out,
  input wire logic quad_protocol_out,
  input wire logic dual_protocol_out,
  input wire logic segment_high_out,
  input wire logic four_byte_addr_out,
  input wire logic wrap_continuous_out,
  input wire logic [5:0] wrap_mask_out,
  input wire logic pe_ready_out
);
  logic [11:0] busy_cnt_reg;
  logic [11:0] busy_cnt_next;
  // Length of the current busy stretch, cleared whenever ready is seen
  assign busy_cnt_next = pe_ready_out ? 12'h000 : busy_cnt_reg + 12'h001;
  always_ff @(posedge mclk_in or posedge rst_in or posedge por_in) begin
    if (rst_in || por_in) begin
      busy_cnt_reg <= 12'h000;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in || por_in);
  a_busy_max: assert property (busy_cnt_reg <= PROG_CYCLES + 4)
    else $error("program busy too long");
  a_busy_min: assert property ($rose(pe_ready_out) |-> busy_cnt_reg >= PROG_CYCLES - 4)
    else $error("program busy too short");
  // Persistent-only settings must not move while a new word programs
  a_cfg_frozen: assert property (!pe_ready_out |-> $stable({exec_mode_out,
    driver_strength_out, dtr_enable_out, data_line_three_hold_out, quad_protocol_out,
    dual_protocol_out, segment_high_out, four_byte_addr_out}))
    else $error("active config changed during program");
  a_oe_in_frame: assert property (dq1_oe_out |-> !cs_n_in)
    else $error("read data driven outside a frame");
  a_quad_over_dual: assert property (!(quad_protocol_out && dual_protocol_out))
    else $error("quad and dual both on");
  a_wrap_cont_mask: assert property (wrap_continuous_out |-> wrap_mask_out == 6'h00)
    else $error("continuous read with a wrap mask");
  a_wrap_mask_set: assert property (!wrap_continuous_out |->
    wrap_mask_out inside {6'h0f, 6'h1f, 6'h3f})
    else $error("bad wrap mask");
  a_dummy_legal: assert property (dummy_cycles_out != 4'h0 && dummy_cycles_out != 4'hf)
    else $error("dummy count out of range");
  a_drv_odd: assert property (driver_strength_out[0] == 1'b1)
    else $error("reserved driver code active");
  c_program: cover property ($fell(pe_ready_out));
  c_quad: cover property (quad_protocol_out);
  c_wrap64: cover property (!wrap_continuous_out && wrap_mask_out == 6'h3f);
endmodule

bind flash_config_registers flash_config_checker #(.PROG_CYCLES(PROG_CYCLES))
    i_flash_config_checker (
  .mclk_in, .rst_in, .por_in, .cs_n_in, .dq1_oe_out, .dummy_cycles_out, .exec_mode_out,
  .driver_strength_out, .dtr_enable_out, .data_line_three_hold_out, .quad_protocol_out,
  .dual_protocol_out, .segment_high_out, .four_byte_addr_out, .wrap_continuous_out,
  .wrap_mask_out, .pe_ready_out
);

// *** verif/serial_host.sv ***
`timescale 1ns/10ps
module serial_host (
  output logic sclk_out,
  output logic cs_n_out,
  output logic dq0_out,
  input wire logic dq1_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    dq0_out = 1'b0;
  end
  // One bit every 48 ns; clock rests low outside frames
  task automatic xfer(input logic [7:0] op, input logic [15:0] wd, input int nbits,
                      output logic [15:0] rd);
    logic [23:0] sh;
    // Small offset keeps link edges clear of system clock edges
    #3;
    sh = {op, wd};
    rd = 16'h0000;
    cs_n_out = 1'b0;
    for (int i = 0; i < nbits + 8; i++) begin
      dq0_out = sh[23 - i];
      #12 sclk_out = 1'b1;
      if (i >= 8) rd = {rd[14:0], dq1_in};
      #24 sclk_out = 1'b0;
      #12;
    end
    cs_n_out = 1'b1;
    dq0_out = ~dq0_out;
    // Long gap lets the core settle; data bit count choice stays with the caller
    #157;
  endtask
endmodule

// *** verif/flash_config_registers_bench.sv ***
`timescale 1ns/10ps
module flash_config_registers_bench;
  localparam logic [16:0] P_DEF = {4'ha, 3'h7, 1'b0, 3'h7, 6'b010000};
  localparam logic [16:0] P_ZERO = {4'ha, 3'h0, 1'b1, 3'h7, 6'b101011};
  localparam logic [16:0] P_MIX = {4'h3, 3'h7, 1'b0, 3'h3, 6'b010100};
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic por_in = 1'b1;
  logic sclk, cs_n, dq0, dq1, dq1_oe, dq1_line;
  logic [3:0] dummy;
  logic [2:0] xmode, drv;
  logic inplace, dtr, hold, quad, dual, seg, four, cont, ready;
  logic [5:0] mask;
  logic [15:0] rd;
  logic [7:0] rt_w [4] = '{8'h70, 8'he5, 8'h1a, 8'h0f};
  logic [11:0] rt_o [4] = '{12'h78f, 12'he9f, 12'h13f, 12'ha40}; // dummy, inplace, cont, mask
  logic [7:0] rt_r [4] = '{8'h70, 8'he1, 8'h1a, 8'h0b};
  int miscompares = 0;
  int check_count = 0;
  // Released line reads high, the inverse of dq1 as the frame reset clears it, never a stale level
  assign dq1_line = dq1_oe ? dq1 : ~dq1;
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  flash_config_registers #(.PROG_CYCLES(60)) i_flash_config_registers (
    .mclk_in(mclk_in), .rst_in(rst_in), .por_in(por_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .dq0_in(dq0), .dq1_out(dq1), .dq1_oe_out(dq1_oe), .dummy_cycles_out(dummy),
    .exec_mode_out(xmode), .execute_in_place_mode_out(inplace), .driver_strength_out(drv),
    .dtr_enable_out(dtr), .data_line_three_hold_out(hold), .quad_protocol_out(quad),
    .dual_protocol_out(dual), .segment_high_out(seg), .four_byte_addr_out(four),
    .wrap_continuous_out(cont), .wrap_mask_out(mask), .pe_ready_out(ready)
  );
  serial_host i_serial_host (.sclk_out(sclk), .cs_n_out(cs_n), .dq0_out(dq0), .dq1_in(dq1_line));
  task check(input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task pcheck(input logic [16:0] exp);
    check({dummy, xmode, inplace, drv, dtr, hold, quad, dual, seg, four}, exp);
  endtask
  task rcheck(input logic [11:0] exp);
    check({5'h00, dummy, inplace, cont, mask}, {5'h00, exp});
  endtask
  task pulse(input logic p);
    @(posedge mclk_in);
    rst_in <= 1'b1;
    por_in <= p;
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    por_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
  endtask
  // Program a persistent word; active settings must hold while it programs
  task pwrite(input logic [15:0] w, input logic [16:0] cur);
    i_serial_host.xfer(cfg_pkg::OP_WR_PERSIST, w, 16, rd);
    check({16'h0000, ready}, 17'h00000);
    pcheck(cur);
    for (int n = 0; n < 100 && ready !== 1'b1; n++) @(posedge mclk_in);
    check({16'h0000, ready}, 17'h00001);
    i_serial_host.xfer(cfg_pkg::OP_RD_PERSIST, 16'h5a5a, 16, rd);
    check({1'b0, rd}, {1'b0, w});
  endtask
  task results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    results();
  end
  initial begin
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    por_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    pcheck(P_DEF);
    rcheck(12'ha40);
    i_serial_host.xfer(cfg_pkg::OP_RD_PERSIST, 16'h5a5a, 16, rd);
    check({1'b0, rd}, 17'h0ffff);
    i_serial_host.xfer(cfg_pkg::OP_RD_RUNTIME, 16'h5a5a, 8, rd);
    check({9'h000, rd[7:0]}, {9'h000, 8'hfb});
    for (int i = 0; i < 4; i++) begin
      i_serial_host.xfer(cfg_pkg::OP_WR_RUNTIME, {rt_w[i], 8'h00}, 8, rd);
      rcheck(rt_o[i]);
      i_serial_host.xfer(cfg_pkg::OP_RD_RUNTIME, 16'h5a5a, 8, rd);
      check({9'h000, rd[7:0]}, {9'h000, rt_r[i]});
    end
    // Cut-short write must leave the runtime word alone
    i_serial_host.xfer(cfg_pkg::OP_WR_RUNTIME, {8'h70, 8'h00}, 4, rd);
    rcheck(12'ha40);
    // A foreign command code carrying a runtime word changes nothing
    i_serial_host.xfer(8'h00, {8'h70, 8'h00}, 8, rd);
    rcheck(12'ha40);
    pwrite(16'h0000, P_DEF);
    pulse(1'b0);
    pcheck(P_ZERO);
    pwrite(16'h3efb, P_ZERO);
    pulse(1'b0);
    pcheck(P_MIX);
    pulse(1'b1);
    pcheck(P_DEF);
    results();
  end
endmodule
